/* design/tsc_stats_top.sv */
// Total octet, total frame, management and transmit size bin counters.
// Assumes frame events arrive as one-cycle pulses from logic on clk,
// with length measured from destination address through CRC.
`timescale 1ns/100ps
module tsc_stats_top
  import tsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [15:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic rx_frame_valid,
  input wire logic [13:0] rx_frame_len,
  input wire logic rx_addr_rejected,
  input wire logic rx_is_broadcast,
  input wire logic tx_frame_done,
  input wire logic [13:0] tx_frame_len,
  input wire logic tx_partial,
  input wire logic tx_flow_ctrl,
  input wire logic tx_mgmt
);
  tsc_reg_if regs ();

  tsc_axil_slave u_slave (
    .clk (clk),
    .reset (reset),
    .s_axil_awaddr (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata (s_axil_wdata),
    .s_axil_wstrb (s_axil_wstrb),
    .s_axil_wvalid (s_axil_wvalid),
    .s_axil_wready (s_axil_wready),
    .s_axil_bresp (s_axil_bresp),
    .s_axil_bvalid (s_axil_bvalid),
    .s_axil_bready (s_axil_bready),
    .s_axil_araddr (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata (s_axil_rdata),
    .s_axil_rresp (s_axil_rresp),
    .s_axil_rvalid (s_axil_rvalid),
    .s_axil_rready (s_axil_rready),
    .regs (regs.bus)
  );

  // Saturating increment
  function automatic logic [31:0] tsc_sat_inc(input logic [31:0] v);
    logic [31:0] r;
    r = (v == TSC_CNT_MAX) ? v : v + 32'h1;
    return r;
  endfunction

  // Byte-lane merge of a write into a held word
  function automatic logic [31:0] tsc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Saturating add of a frame length to a 64-bit total
  function automatic logic [63:0] tsc_oct_add(input logic [63:0] base,
                                              input logic [13:0] len);
    logic [64:0] sum;
    logic [63:0] r;
    sum = {1'b0, base} + {51'h0, len};
    r = sum[64] ? TSC_OCT_MAX : sum[63:0];
    return r;
  endfunction

  logic [1:0] ctrl_r;
  logic rx_en;
  logic tx_en;
  logic [31:0] mgmt_tx_frame_count_r;
  logic [31:0] rx_total_frames_r;
  logic [31:0] tx_total_frames_r;
  logic [63:0] rx_total_octets_r;
  logic [63:0] tx_total_octets_r;
  logic [31:0] bin_r [TSC_NUM_BINS];
  logic rx_count;
  logic tx_count;
  logic mgmt_count;
  logic rx_oct_clr;
  logic tx_oct_clr;
  logic wr_ctrl;
  logic wr_rx_frames;
  logic wr_tx_frames;
  logic wr_tx_oct_lo;
  logic [TSC_NUM_BINS-1:0] wr_bin;
  logic [TSC_NUM_BINS-1:0] bin_hit;
  logic [31:0] rd_data_c;
  logic rd_err_c;
  logic wr_err_c;

  assign rx_en = ctrl_r[TSC_CTRL_RX_EN_BIT];
  assign tx_en = ctrl_r[TSC_CTRL_TX_EN_BIT];

  // Frame qualification
  assign rx_count = rx_frame_valid && rx_en
                    && (!rx_addr_rejected || rx_is_broadcast);
  assign tx_count = tx_frame_done && tx_en
                    && !tx_partial;
  assign mgmt_count = tx_count && tx_mgmt;

  // Clear of a whole octet total on upper-half read
  assign rx_oct_clr = regs.rd_en && (regs.rd_addr == TSC_OFF_RX_OCT_HI);
  assign tx_oct_clr = regs.rd_en && (regs.rd_addr == TSC_OFF_TX_OCT_HI);

  // Write decode
  assign wr_ctrl = regs.wr_en && (regs.wr_addr == TSC_OFF_CTRL);
  assign wr_rx_frames = regs.wr_en && (regs.wr_addr == TSC_OFF_RX_FRAMES);
  assign wr_tx_frames = regs.wr_en && (regs.wr_addr == TSC_OFF_TX_FRAMES);
  assign wr_tx_oct_lo = regs.wr_en && (regs.wr_addr == TSC_OFF_TX_OCT_LO);

  // Control register
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= TSC_CTRL_RESET;
    end else if (wr_ctrl && regs.wr_strb[0]) begin
      ctrl_r <= regs.wr_data[1:0];
    end
  end

  // Management transmit frames
  always_ff @(posedge clk) begin
    if (reset) begin
      mgmt_tx_frame_count_r <= TSC_CNT_RESET;
    end else if (mgmt_count) begin
      mgmt_tx_frame_count_r <= tsc_sat_inc(mgmt_tx_frame_count_r);
    end
  end

  // Received frame total
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_total_frames_r <= TSC_CNT_RESET;
    end else if (wr_rx_frames) begin
      rx_total_frames_r <= tsc_merge(rx_total_frames_r, regs.wr_data, regs.wr_strb);
    end else if (rx_count) begin
      rx_total_frames_r <= tsc_sat_inc(rx_total_frames_r);
    end
  end

  // Sent frame total
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_total_frames_r <= TSC_CNT_RESET;
    end else if (wr_tx_frames) begin
      tx_total_frames_r <= tsc_merge(tx_total_frames_r, regs.wr_data, regs.wr_strb);
    end else if (tx_count) begin
      tx_total_frames_r <= tsc_sat_inc(tx_total_frames_r);
    end
  end

  // Received octet total; a frame in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_total_octets_r <= TSC_OCT_RESET;
    end else if (rx_count) begin
      rx_total_octets_r <= tsc_oct_add(rx_oct_clr ? TSC_OCT_RESET : rx_total_octets_r,
                                       rx_frame_len);
    end else if (rx_oct_clr) begin
      rx_total_octets_r <= TSC_OCT_RESET;
    end
  end

  // Sent octet total, flow control frames included
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_total_octets_r <= TSC_OCT_RESET;
    end else if (wr_tx_oct_lo) begin
      tx_total_octets_r[31:0] <= tsc_merge(tx_total_octets_r[31:0], regs.wr_data,
                                           regs.wr_strb);
    end else if (tx_count) begin
      tx_total_octets_r <= tsc_oct_add(tx_oct_clr ? TSC_OCT_RESET : tx_total_octets_r,
                                       tx_frame_len);
    end else if (tx_oct_clr) begin
      tx_total_octets_r <= TSC_OCT_RESET;
    end
  end

  // Transmit size bins; ranges do not overlap so one bin at most is hit
  genvar gi;
  generate
    for (gi = 0; gi < TSC_NUM_BINS; gi++) begin : g_bin
      if (gi == 0) begin : g_first
        assign bin_hit[gi] = tx_count && !tx_flow_ctrl
                             && (tx_frame_len == TSC_BIN_LO[gi]);
      end else begin : g_range
        assign bin_hit[gi] = tx_count
                             && (tx_frame_len >= TSC_BIN_LO[gi])
                             && (tx_frame_len <= TSC_BIN_HI[gi]);
      end
      assign wr_bin[gi] = regs.wr_en && (regs.wr_addr == TSC_OFF_BIN[gi]);

      always_ff @(posedge clk) begin
        if (reset) begin
          bin_r[gi] <= TSC_CNT_RESET;
        end else if (wr_bin[gi]) begin
          bin_r[gi] <= tsc_merge(bin_r[gi], regs.wr_data, regs.wr_strb);
        end else if (bin_hit[gi]) begin
          bin_r[gi] <= tsc_sat_inc(bin_r[gi]);
        end
      end
    end
  endgenerate

  // Read mux, unmapped addresses answer with an error
  always_comb begin
    rd_data_c = 32'h0;
    rd_err_c = 1'b0;
    case (regs.rd_addr)
      TSC_OFF_MGMT_TX: rd_data_c = mgmt_tx_frame_count_r;
      TSC_OFF_RX_OCT_LO: rd_data_c = rx_total_octets_r[31:0];
      TSC_OFF_RX_OCT_HI: rd_data_c = rx_total_octets_r[63:32];
      TSC_OFF_TX_OCT_LO: rd_data_c = tx_total_octets_r[31:0];
      TSC_OFF_TX_OCT_HI: rd_data_c = tx_total_octets_r[63:32];
      TSC_OFF_RX_FRAMES: rd_data_c = rx_total_frames_r;
      TSC_OFF_TX_FRAMES: rd_data_c = tx_total_frames_r;
      TSC_OFF_CTRL: rd_data_c = {30'h0, ctrl_r};
      default: begin
        rd_err_c = 1'b1;
        for (int i = 0; i < TSC_NUM_BINS; i++) begin
          if (regs.rd_addr == TSC_OFF_BIN[i]) begin
            rd_data_c = bin_r[i];
            rd_err_c = 1'b0;
          end
        end
      end
    endcase
  end

  // Write decode error for addresses outside the map
  always_comb begin
    wr_err_c = 1'b1;
    case (regs.wr_addr)
      TSC_OFF_MGMT_TX,
      TSC_OFF_RX_OCT_LO,
      TSC_OFF_RX_OCT_HI,
      TSC_OFF_TX_OCT_LO,
      TSC_OFF_TX_OCT_HI,
      TSC_OFF_RX_FRAMES,
      TSC_OFF_TX_FRAMES,
      TSC_OFF_CTRL: wr_err_c = 1'b0;
      default: begin
        for (int i = 0; i < TSC_NUM_BINS; i++) begin
          if (regs.wr_addr == TSC_OFF_BIN[i]) begin
            wr_err_c = 1'b0;
          end
        end
      end
    endcase
  end

  assign regs.rd_data = rd_data_c;
  assign regs.rd_err = rd_err_c;
  assign regs.wr_err = wr_err_c;
endmodule

/* design/tsc_pkg.sv */
// Constants, offsets and size bins of the total and transmit size counters.
// Assumes a single 40 MHz core clock and a 16-bit AXI4-Lite byte address.
package tsc_pkg;
  localparam int TSC_ADDR_W = 16;
  localparam int TSC_LEN_W = 14;
  localparam int TSC_NUM_BINS = 5;

  localparam logic [15:0] TSC_OFF_MGMT_TX = 16'h40bc;
  localparam logic [15:0] TSC_OFF_RX_OCT_LO = 16'h40c0;
  localparam logic [15:0] TSC_OFF_RX_OCT_HI = 16'h40c4;
  localparam logic [15:0] TSC_OFF_TX_OCT_LO = 16'h40c8;
  localparam logic [15:0] TSC_OFF_TX_OCT_HI = 16'h40cc;
  localparam logic [15:0] TSC_OFF_RX_FRAMES = 16'h40d0;
  localparam logic [15:0] TSC_OFF_TX_FRAMES = 16'h40d4;
  localparam logic [15:0] TSC_OFF_CTRL = 16'h4200;
  localparam logic [15:0] TSC_OFF_BIN [TSC_NUM_BINS] = '{
    16'h40d8, 16'h40dc, 16'h40e0, 16'h40e4, 16'h40e8};

  localparam logic [13:0] TSC_BIN_LO [TSC_NUM_BINS] = '{
    14'h0040, 14'h0041, 14'h0080, 14'h0100, 14'h0200};
  localparam logic [13:0] TSC_BIN_HI [TSC_NUM_BINS] = '{
    14'h0040, 14'h007f, 14'h00ff, 14'h01ff, 14'h03ff};

  localparam int TSC_CTRL_RX_EN_BIT = 0;
  localparam int TSC_CTRL_TX_EN_BIT = 1;
  localparam logic [1:0] TSC_CTRL_RESET = 2'h3;
  localparam logic [31:0] TSC_CNT_RESET = 32'h0;
  localparam logic [63:0] TSC_OCT_RESET = 64'h0;
  localparam logic [31:0] TSC_CNT_MAX = 32'hffffffff;
  localparam logic [63:0] TSC_OCT_MAX = 64'hffffffffffffffff;

  localparam logic [1:0] TSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSC_RESP_DECERR = 2'h3;
endpackage

/* design/tsc_reg_if.sv */
// Register access strobes between the bus front end and the counter bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface tsc_reg_if;
  logic wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_err, rd_data, rd_err);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

/* design/tsc_axil_slave.sv */
// AXI4-Lite slave front end turning bus transfers into register strobes.
// Assumes the register side answers reads and decode combinationally.
`timescale 1ns/100ps
module tsc_axil_slave
  import tsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [15:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  tsc_reg_if.bus regs
);
  logic aw_held_r;
  logic w_held_r;
  logic [15:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;

  assign s_axil_awready = !aw_held_r && !s_axil_bvalid;
  assign s_axil_wready = !w_held_r && !s_axil_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axil_bvalid;
  assign s_axil_arready = !s_axil_rvalid;

  assign regs.wr_en = wr_fire;
  assign regs.wr_addr = awaddr_r;
  assign regs.wr_data = wdata_r;
  assign regs.wr_strb = wstrb_r;
  assign regs.rd_en = s_axil_arvalid && s_axil_arready;
  assign regs.rd_addr = s_axil_araddr;

  // Write address capture
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 16'h0;
    end else if (s_axil_awvalid && s_axil_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axil_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge clk) begin
    if (reset) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else if (s_axil_wvalid && s_axil_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axil_wdata;
      wstrb_r <= s_axil_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= TSC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axil_bvalid <= 1'b1;
      s_axil_bresp <= regs.wr_err ? TSC_RESP_DECERR : TSC_RESP_OKAY;
    end else if (s_axil_bready) begin
      s_axil_bvalid <= 1'b0;
    end
  end

  // Read data and response
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0;
      s_axil_rresp <= TSC_RESP_OKAY;
    end else if (regs.rd_en) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= regs.rd_data;
      s_axil_rresp <= regs.rd_err ? TSC_RESP_DECERR : TSC_RESP_OKAY;
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end
endmodule

/* tb/tsc_mac_model.sv */
// Frame event source standing in for the MAC receive and transmit paths.
// Assumes it shares the counter bank clock; every event is a one-cycle pulse.
`timescale 1ns/100ps
module tsc_mac_model (
  input wire logic clk,
  output logic rx_frame_valid,
  output logic [13:0] rx_frame_len,
  output logic rx_addr_rejected,
  output logic rx_is_broadcast,
  output logic tx_frame_done,
  output logic [13:0] tx_frame_len,
  output logic tx_partial,
  output logic tx_flow_ctrl,
  output logic tx_mgmt
);
  initial begin
    rx_frame_valid = 1'b0;
    tx_frame_done = 1'b0;
    {rx_frame_len, rx_addr_rejected, rx_is_broadcast} = '0;
    {tx_frame_len, tx_partial, tx_flow_ctrl, tx_mgmt} = '0;
  end
  // Qualifiers flip once the pulse is gone, so stale values are never read
  task automatic send_rx(input logic [13:0] len, input logic rej, input logic bc);
    @(posedge clk);
    rx_frame_valid <= 1'b1;
    {rx_frame_len, rx_addr_rejected, rx_is_broadcast} <= {len, rej, bc};
    @(posedge clk);
    rx_frame_valid <= 1'b0;
    {rx_frame_len, rx_addr_rejected, rx_is_broadcast} <= ~{len, rej, bc};
  endtask
  task automatic send_tx(input logic [13:0] len, input logic p, input logic f, input logic m);
    @(posedge clk);
    tx_frame_done <= 1'b1;
    {tx_frame_len, tx_partial, tx_flow_ctrl, tx_mgmt} <= {len, p, f, m};
    @(posedge clk);
    tx_frame_done <= 1'b0;
    {tx_frame_len, tx_partial, tx_flow_ctrl, tx_mgmt} <= ~{len, p, f, m};
  endtask
endmodule

/* tb/tsc_stats_assertions.sv */
// Checker on the register bus ports of the counter bank top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module tsc_stats_assertions
  import tsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic [15:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic rx_frame_valid,
  input wire logic tx_frame_done
);
  logic rx_clean_r;
  logic tx_clean_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_rd;
    s_axil_arvalid && s_axil_arready;
  endsequence
  sequence s_wr;
    s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
  endsequence
  // Octet totals known zero since reset or an upper-half read
  always_ff @(posedge clk) begin
    if (reset) rx_clean_r <= 1'b1;
    else if (rx_frame_valid) rx_clean_r <= 1'b0;
    else if (s_axil_arvalid && s_axil_arready
             && s_axil_araddr == TSC_OFF_RX_OCT_HI) rx_clean_r <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (reset) tx_clean_r <= 1'b1;
    else if (tx_frame_done || s_axil_awvalid) tx_clean_r <= 1'b0;
    else if (s_axil_arvalid && s_axil_arready
             && s_axil_araddr == TSC_OFF_TX_OCT_HI) tx_clean_r <= 1'b1;
  end
  property p_rd_answer;
    s_rd |=> s_axil_rvalid;
  endproperty
  property p_rd_hold;
    s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata);
  endproperty
  property p_rd_err;
    s_rd ##0 (s_axil_araddr[1:0] != 2'h0)
      |=> s_axil_rresp == TSC_RESP_DECERR && s_axil_rdata == 32'h0;
  endproperty
  property p_wr_answer;
    s_wr |=> !s_axil_awready ##1 s_axil_bvalid;
  endproperty
  property p_wr_ro;
    s_wr ##0 (s_axil_awaddr == TSC_OFF_MGMT_TX) |=> ##1 s_axil_bresp == TSC_RESP_OKAY;
  endproperty
  property p_reset_idle;
    $fell(reset) |-> !s_axil_rvalid && !s_axil_bvalid && s_axil_rdata == 32'h0;
  endproperty
  property p_rx_clear;
    s_rd ##0 (rx_clean_r && s_axil_araddr[15:3] == TSC_OFF_RX_OCT_LO[15:3])
      |=> s_axil_rdata == 32'h0;
  endproperty
  property p_tx_clear;
    s_rd ##0 (tx_clean_r && s_axil_araddr[15:3] == TSC_OFF_TX_OCT_LO[15:3])
      |=> s_axil_rdata == 32'h0;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  a_wr_ro: assert property (p_wr_ro) else $error("read-only write refused");
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");
  a_rx_clear: assert property (p_rx_clear) else $error("rx octets not cleared");
  a_tx_clear: assert property (p_tx_clear) else $error("tx octets not cleared");
endmodule
bind tsc_stats_top tsc_stats_assertions i_chk (.clk(clk), .reset(reset),
  .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
  .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid),
  .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
  .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
  .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
  .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
  .rx_frame_valid(rx_frame_valid), .tx_frame_done(tx_frame_done));

/* tb/tsc_stats_top_test.sv */
// Self-checking bench driving frame events and reading counters over the bus.
// Assumes the MAC model shares the clock and the design answers within 200 cycles.
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tsc_stats_top_test
  import tsc_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, rxv, rrej, rbc, txd, txp, txf, txm;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [13:0] rxl, txl;
  int errors = 0, num_checks = 0;
  logic [31:0] exp_w [12] = '{default: '0};
  logic [63:0] ro = '0, to_ = '0;
  logic rx_en = 1'b1, tx_en = 1'b1;
  localparam logic [15:0] ADDR [12] = '{16'h40bc, 16'h40c0, 16'h40c4, 16'h40c8, 16'h40cc,
    16'h40d0, 16'h40d4, 16'h40d8, 16'h40dc, 16'h40e0, 16'h40e4, 16'h40e8};
  localparam int LO [5] = '{64, 65, 128, 256, 512};
  localparam int HI [5] = '{64, 127, 255, 511, 1023};
  localparam int LEN [13] = '{64, 64, 65, 127, 128, 255, 256, 511, 512, 1023, 1024, 100, 200};
  always #12.5 clk = ~clk;
  tsc_stats_top i_dut (.clk(clk), .reset(reset), .s_axil_awaddr(awaddr),
    .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
    .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
    .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
    .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
    .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .rx_frame_valid(rxv), .rx_frame_len(rxl), .rx_addr_rejected(rrej), .rx_is_broadcast(rbc),
    .tx_frame_done(txd), .tx_frame_len(txl), .tx_partial(txp), .tx_flow_ctrl(txf),
    .tx_mgmt(txm));
  tsc_mac_model i_mac (.clk(clk), .rx_frame_valid(rxv), .rx_frame_len(rxl),
    .rx_addr_rejected(rrej), .rx_is_broadcast(rbc), .tx_frame_done(txd), .tx_frame_len(txl),
    .tx_partial(txp), .tx_flow_ctrl(txf), .tx_mgmt(txm));
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    n++;
    if (n > 200) begin
      errors++;
      $display("[ERR] bus wait exp answer got none");
      summarize;
    end
  endtask
  function automatic logic [31:0] inc(input logic [31:0] x);
    return (x == 32'hffffffff) ? x : x + 32'h1;
  endfunction
  task automatic rd(input logic [15:0] a, output logic [31:0] dd, output logic [1:0] rr);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge clk); tick(n); end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin @(posedge clk); tick(n); end while (rvalid !== 1'b1);
    dd = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    {awaddr, wdata, wstrb} <= {a, v, s};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (!wd && wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
      tick(n);
    end
    do begin @(posedge clk); tick(n); end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic tx(input int len, input logic p, input logic f, input logic m);
    i_mac.send_tx(14'(len), p, f, m);
    if (tx_en && !p) begin
      to_ = to_ + 64'(len);
      exp_w[6] = inc(exp_w[6]);
      if (m) exp_w[0] = inc(exp_w[0]);
      for (int i = 0; i < 5; i++)
        if (len >= LO[i] && len <= HI[i] && !(i == 0 && f)) exp_w[7+i] = inc(exp_w[7+i]);
    end
  endtask
  task automatic rx(input int len, input logic rej, input logic bc);
    i_mac.send_rx(14'(len), rej, bc);
    if (rx_en && (!rej || bc)) begin
      ro = ro + 64'(len);
      exp_w[5] = inc(exp_w[5]);
    end
  endtask
  // Low halves are read before high halves, so each pass clears the octet totals
  task automatic check_all;
    {exp_w[2], exp_w[1], exp_w[4], exp_w[3]} = {ro, to_};
    for (int i = 0; i < 12; i++) begin
      rd(ADDR[i], d, r);
      `CHK($sformatf("reg %h", ADDR[i]), exp_w[i], d)
    end
    ro = '0;
    to_ = '0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check_all;
    rd(TSC_OFF_CTRL, d, r);
    `CHK("ctrl", 32'h3, d)
    for (int i = 0; i < 13; i++) tx(LEN[i], i == 11, i == 1, i == 12);
    rx(60, 1'b0, 1'b0);
    rx(100, 1'b1, 1'b1);
    rx(80, 1'b1, 1'b0);
    rx(1518, 1'b0, 1'b0);
    check_all;
    rx(300, 1'b0, 1'b0);
    tx(70, 1'b0, 1'b0, 1'b0);
    for (int j = 2; j <= 4; j += 2) begin
      rd(ADDR[j], d, r);
      `CHK("octets high", 32'h0, d)
      rd(ADDR[j-1], d, r);
      `CHK("octets low after clear", 32'h0, d)
    end
    ro = '0;
    to_ = '0;
    wr(TSC_OFF_CTRL, 32'h0, 4'h1);
    {rx_en, tx_en} = 2'h0;
    tx(64, 1'b0, 1'b0, 1'b1);
    rx(64, 1'b0, 1'b0);
    wr(TSC_OFF_CTRL, 32'h3, 4'h1);
    {rx_en, tx_en} = 2'h3;
    check_all;
    wr(ADDR[6], 32'hffffffff, 4'hf);
    wr(ADDR[7], 32'hffffffff, 4'hf);
    wr(ADDR[5], 32'h12345678, 4'h1);
    wr(ADDR[0], 32'h5a, 4'hf);
    `CHK("read-only write resp", TSC_RESP_OKAY, r)
    {exp_w[6], exp_w[7], exp_w[5][7:0]} = {64'hffffffffffffffff, 8'h78};
    wr(ADDR[3], 32'h100, 4'hf);
    `CHK("tx octets low write resp", TSC_RESP_OKAY, r)
    to_ = 64'h100;
    tx(64, 1'b0, 1'b0, 1'b0);
    check_all;
    rd(16'h40c2, d, r);
    `CHK("unaligned read resp", TSC_RESP_DECERR, r)
    rd(16'h4100, d, r);
    `CHK("unmapped read resp", TSC_RESP_DECERR, r)
    wr(16'h4100, 32'h1, 4'hf);
    `CHK("unmapped write resp", TSC_RESP_DECERR, r)
    summarize;
  end
endmodule
